// [src/transceiver_gpio_pin_port.sv]
// general-purpose pin port with its register file behind the serial slave
`timescale 1ns/1ns
// Behaviour
// RULE1: host enables pin 4 output driver by writing bit 4 to output enable.
// RULE2: set register with bit 4 drives pin 4 high; clear register drives it low.
// RULE3: shared transmit pin carries pin 4 data bit when configured as output.
// RULE4: host enables input buffers of pins 6 and 0 before reading switches.
// RULE5: input register shows pin 6 in bit 6 and pin 0 in bit 0.
// RULE6: reading the input register returns current levels of input-enabled pins.
// RULE7: with pin 4 an output, high lights the LED, low turns it off.
// RULE8: every pin register is reachable by serial-bus reads and writes. Set and clear read as zero, and writes to the input register are ignored.
// RULE9: set and clear change only bits written as one, visible on readback.
// RULE10: a pin with its input buffer disabled reads as zero.
module transceiver_gpio_pin_port
  import pin_port_pkg::*;
#(
  parameter int NPINS = 8,
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  input wire logic I_CLK, // system clock, 100 MHz
  input wire logic I_RST_N, // asynchronous reset, active low
  input wire logic I_SCL, // serial bus clock
  input wire logic I_SDA, // serial bus data level
  output logic O_SDA_OUT, // serial data drive value, always low
  output logic O_SDA_OE, // serial data drive enable
  input wire logic [NPINS-1:0] I_PIN_IN, // pin levels
  output logic [NPINS-1:0] O_PIN_OUT, // pin drive values
  output logic [NPINS-1:0] O_PIN_OE, // pin drive enables
  output logic O_LED // user LED on pin 4, high is lit
);
  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_meta_q, rst_n;
  // release through two stages so the register file leaves reset cleanly
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end
  // ************************************************************
  // bus slave
  // ************************************************************
  logic wr_en, sda_oe;
  logic [7:0] addr, wr_data, rd_data;
  serial_reg_slave #(.DEV_ADDR(DEV_ADDR)) u_slave (
    .clk(I_CLK),
    .rst_n(rst_n),
    .i_scl(I_SCL),
    .i_sda(I_SDA),
    .i_rd_data(rd_data),
    .o_sda_oe(sda_oe),
    .o_wr_en(wr_en),
    .o_addr(addr),
    .o_wr_data(wr_data)
  );
  assign O_SDA_OE = sda_oe;
  // open drain: the drive value never leaves low
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) O_SDA_OUT <= 1'b0;
    else O_SDA_OUT <= 1'b0;
  end
  // ************************************************************
  // register file
  // ************************************************************
  logic [NPINS-1:0] data_q, oen_q, ien_q, int_en_q, int_inv_q, cfg_q;
  // data register; set and clear touch only bits written as one
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      data_q <= NPINS'(RST_REG);
    end else if (wr_en) begin
      if (addr == OFS_DATA) data_q <= wr_data[NPINS-1:0];
      if (addr == OFS_DATA_SET) data_q <= data_q | wr_data[NPINS-1:0]; // RULE2 RULE9
      if (addr == OFS_DATA_CLEAR) data_q <= data_q & ~wr_data[NPINS-1:0]; // RULE2 RULE9
    end
  end
  // enables and interrupt setup; interrupt fields are stored only
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      oen_q <= NPINS'(RST_REG);
      ien_q <= NPINS'(RST_REG);
      int_en_q <= NPINS'(RST_REG);
      int_inv_q <= NPINS'(RST_REG);
      cfg_q <= NPINS'(RST_REG);
    end else if (wr_en) begin
      if (addr == OFS_OUT_EN) oen_q <= wr_data[NPINS-1:0]; // RULE1
      if (addr == OFS_IN_EN) ien_q <= wr_data[NPINS-1:0]; // RULE4
      if (addr == OFS_INT_EN) int_en_q <= wr_data[NPINS-1:0];
      if (addr == OFS_INT_INV) int_inv_q <= wr_data[NPINS-1:0];
      if (addr == OFS_PIN_CFG) cfg_q <= wr_data[NPINS-1:0];
    end
  end
  // ************************************************************
  // pin inputs
  // ************************************************************
  logic [NPINS-1:0] pin_f_q, level_q;
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_in
      logic [2:0] s_q;
      // three stages; first stage feeds only the second
      always_ff @(posedge I_CLK or negedge rst_n) begin
        if (!rst_n) begin
          s_q <= 3'h0;
          pin_f_q[gi] <= 1'b0;
        end else begin
          s_q <= {s_q[1:0], I_PIN_IN[gi]};
          if (s_q[1] == s_q[2]) pin_f_q[gi] <= s_q[2];
        end
      end
    end
  endgenerate
  // gated levels; a disabled buffer reads zero
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) level_q <= NPINS'(RST_REG);
    else level_q <= pin_f_q & ien_q; // RULE5 RULE6 RULE10
  end
  // ************************************************************
  // read mux
  // ************************************************************
  // write-only and unmapped offsets answer zero
  // the pointer drives the mux directly, so a read costs no extra cycle
  always_comb begin
    rd_data = RD_NONE;
    unique case (addr)
      OFS_DATA: rd_data[NPINS-1:0] = data_q; // RULE9
      OFS_OUT_EN: rd_data[NPINS-1:0] = oen_q;
      OFS_IN_EN: rd_data[NPINS-1:0] = ien_q;
      OFS_IN_LEVEL: rd_data[NPINS-1:0] = level_q; // RULE6
      OFS_INT_EN: rd_data[NPINS-1:0] = int_en_q;
      OFS_INT_INV: rd_data[NPINS-1:0] = int_inv_q;
      OFS_PIN_CFG: rd_data[NPINS-1:0] = cfg_q;
      default: rd_data = RD_NONE;
    endcase
  end
  // ************************************************************
  // pin drive
  // ************************************************************
  // pins follow the data and enable registers one cycle later
  always_ff @(posedge I_CLK or negedge rst_n) begin
    if (!rst_n) begin
      O_PIN_OUT <= NPINS'(RST_REG);
      O_PIN_OE <= NPINS'(RST_REG);
      O_LED <= 1'b0;
    end else begin
      O_PIN_OUT <= data_q; // RULE3
      O_PIN_OE <= oen_q; // RULE3
      O_LED <= data_q[PIN_LED] & oen_q[PIN_LED]; // RULE7
    end
  end
  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!rst_n);
  // pin-side checks: drive values, LED, input levels and data updates
  a_set_drives_high: assert property ( // RULE2
    wr_en && addr == OFS_DATA_SET && wr_data[PIN_LED] |=> ##1 O_PIN_OUT[PIN_LED])
    else $error("set write did not drive pin high");
  a_clear_drives_low: assert property ( // RULE2
    wr_en && addr == OFS_DATA_CLEAR && wr_data[PIN_LED] |=> ##1 !O_PIN_OUT[PIN_LED])
    else $error("clear write did not drive pin low");
  a_pin4_carries_data: assert property ( // RULE3
    oen_q[PIN_LED] ##1 1'b1 |-> O_PIN_OE[PIN_LED] && O_PIN_OUT[PIN_LED] == $past(data_q[PIN_LED]))
    else $error("shared pin does not carry data bit");
  a_level_bit_map: assert property ( // RULE5
    ##1 level_q[PIN_SWITCH_A] == $past(pin_f_q[PIN_SWITCH_A] & ien_q[PIN_SWITCH_A])
    && level_q[PIN_SWITCH_B] == $past(pin_f_q[PIN_SWITCH_B] & ien_q[PIN_SWITCH_B]))
    else $error("switch levels in wrong bits");
  a_level_readback: assert property ( // RULE6
    addr == OFS_IN_LEVEL |-> rd_data[NPINS-1:0] == level_q)
    else $error("input register read wrong value");
  a_led_lit: assert property ( // RULE7
    data_q[PIN_LED] && oen_q[PIN_LED] |=> O_LED)
    else $error("LED dark while pin 4 drives high");
  a_led_dark: assert property ( // RULE7
    !(data_q[PIN_LED] && oen_q[PIN_LED]) |=> !O_LED)
    else $error("LED lit while pin 4 is low or released");
  a_write_reaches: assert property ( // RULE8
    wr_en && addr == OFS_OUT_EN |=> oen_q == $past(wr_data[NPINS-1:0]) ##1 O_PIN_OE == $past(oen_q))
    else $error("output enable write lost");
  a_set_only_ones: assert property ( // RULE9
    wr_en && addr == OFS_DATA_SET |=> data_q == ($past(data_q) | $past(wr_data[NPINS-1:0])))
    else $error("set touched other bits");
  a_clear_only_ones: assert property ( // RULE9
    wr_en && addr == OFS_DATA_CLEAR |=> data_q == ($past(data_q) & ~$past(wr_data[NPINS-1:0])))
    else $error("clear touched other bits");
  a_disabled_zero: assert property ( // RULE10
    ien_q == '0 [*2] |-> level_q == '0)
    else $error("disabled pin read nonzero");
  // bus-side checks: loads, readback paths and pin follow-through
  a_data_loads: assert property ( // RULE8
    wr_en && addr == OFS_DATA |=> data_q == $past(wr_data[NPINS-1:0]))
    else $error("data write not loaded");
  a_in_enable_loads: assert property ( // RULE8
    wr_en && addr == OFS_IN_EN |=> ien_q == $past(wr_data[NPINS-1:0]))
    else $error("input enable write lost");
  a_int_enable_loads: assert property ( // RULE8
    wr_en && addr == OFS_INT_EN |=> int_en_q == $past(wr_data[NPINS-1:0]))
    else $error("interrupt enable write lost");
  a_cfg_loads: assert property ( // RULE8
    wr_en && addr == OFS_PIN_CFG |=> cfg_q == $past(wr_data[NPINS-1:0]))
    else $error("pin configuration write lost");
  a_enable_readback: assert property ( // RULE8
    addr == OFS_OUT_EN |-> rd_data[NPINS-1:0] == oen_q)
    else $error("output enable read wrong value");
  a_write_only_zero: assert property ( // RULE8
    addr == OFS_DATA_SET || addr == OFS_DATA_CLEAR |-> rd_data == RD_NONE)
    else $error("write-only register read nonzero");
  a_unmapped_zero: assert property ( // RULE8
    addr > OFS_PIN_CFG || addr < OFS_DATA |-> rd_data == RD_NONE)
    else $error("unmapped offset read nonzero");
  a_pins_follow: assert property ( // RULE3
    1'b1 |=> O_PIN_OUT == $past(data_q) && O_PIN_OE == $past(oen_q))
    else $error("pin drive lags registers");
  c_led_on: cover property (wr_en && addr == OFS_DATA_SET ##[1:4] O_LED);
  c_led_off: cover property (O_LED ##[1:100] !O_LED);
  c_switch_seen: cover property (addr == OFS_IN_LEVEL && level_q[PIN_SWITCH_A]);
  c_both_switches: cover property (level_q[PIN_SWITCH_A] && level_q[PIN_SWITCH_B]);
  c_burst_write: cover property (wr_en ##[1:400] wr_en);
endmodule

// [src/pin_port_pkg.sv]
// package with register map, reset values and bus constants for the pin port
package pin_port_pkg;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] OFS_DATA = 8'h4A;
  localparam logic [7:0] OFS_DATA_SET = 8'h4B;
  localparam logic [7:0] OFS_DATA_CLEAR = 8'h4C;
  localparam logic [7:0] OFS_OUT_EN = 8'h4D;
  localparam logic [7:0] OFS_IN_EN = 8'h4E;
  localparam logic [7:0] OFS_IN_LEVEL = 8'h4F;
  localparam logic [7:0] OFS_INT_EN = 8'h50;
  localparam logic [7:0] OFS_INT_INV = 8'h51;
  localparam logic [7:0] OFS_PIN_CFG = 8'h52;
  // ************************************************************
  // reset values and read answers
  // ************************************************************
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RD_NONE = 8'h00;
  // ************************************************************
  // pin positions on the board
  // ************************************************************
  localparam int PIN_LED = 4;
  localparam int PIN_SWITCH_A = 6;
  localparam int PIN_SWITCH_B = 0;
  // ************************************************************
  // serial bus
  // ************************************************************
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h69;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b011,
    ST_WDATA = 3'b010,
    ST_WACK = 3'b110,
    ST_RDATA = 3'b111,
    ST_RACK = 3'b101
  } bus_state_t;
endpackage

// [src/serial_reg_slave.sv]
// serial two-wire register slave with auto-incrementing register pointer
`timescale 1ns/1ns
module serial_reg_slave
  import pin_port_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronised reset, active low
  input wire logic i_scl, // serial clock pin
  input wire logic i_sda, // serial data pin level
  input wire logic [7:0] i_rd_data, // data at the pointer
  output logic o_sda_oe, // pulls data line low when high
  output logic o_wr_en, // one-cycle register write
  output logic [7:0] o_addr, // register pointer
  output logic [7:0] o_wr_data // write data
);
  // ************************************************************
  // input filtering
  // ************************************************************
  logic [2:0] scl_s_q, sda_s_q;
  logic scl_f_q, sda_f_q, scl_p_q, sda_p_q;
  // three stages; a level counts once the last two agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[1:0], i_scl};
      sda_s_q <= {sda_s_q[1:0], i_sda};
      if (scl_s_q[1] == scl_s_q[2]) scl_f_q <= scl_s_q[2];
      if (sda_s_q[1] == sda_s_q[2]) sda_f_q <= sda_s_q[2];
      scl_p_q <= scl_f_q;
      sda_p_q <= sda_f_q;
    end
  end
  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_f_q & ~scl_p_q;
  assign scl_fall = ~scl_f_q & scl_p_q;
  assign bus_start = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
  assign bus_stop = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;
  // ************************************************************
  // byte engine
  // ************************************************************
  bus_state_t state_q;
  logic [7:0] sr_q, tx_q;
  logic [3:0] cnt_q;
  logic rw_q, first_q, nack_q;
  // start and stop win over any bit event; no clock stretching is done
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      sr_q <= 8'h00;
      tx_q <= 8'h00;
      cnt_q <= 4'h0;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      nack_q <= 1'b0;
      o_sda_oe <= 1'b0;
      o_wr_en <= 1'b0;
      o_addr <= 8'h00;
      o_wr_data <= 8'h00;
    end else begin
      o_wr_en <= 1'b0;
      if (bus_start) begin
        state_q <= ST_ADDR;
        cnt_q <= 4'h0;
        o_sda_oe <= 1'b0;
      end else if (bus_stop) begin
        state_q <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        unique case (state_q)
          ST_IDLE: begin
            o_sda_oe <= 1'b0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              sr_q <= {sr_q[6:0], sda_f_q};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
              rw_q <= sr_q[0];
              if (sr_q[7:1] == DEV_ADDR) begin
                state_q <= ST_ADDR_ACK;
                o_sda_oe <= 1'b1;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_ADDR_ACK: begin
            if (scl_fall) begin
              cnt_q <= 4'h0;
              if (rw_q) begin
                state_q <= ST_RDATA;
                tx_q <= i_rd_data;
                o_sda_oe <= ~i_rd_data[7];
              end else begin
                state_q <= ST_WDATA;
                first_q <= 1'b1;
                o_sda_oe <= 1'b0;
              end
            end
          end
          ST_WDATA: begin
            if (scl_rise) begin
              sr_q <= {sr_q[6:0], sda_f_q};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
              state_q <= ST_WACK;
              o_sda_oe <= 1'b1;
              if (first_q) begin
                o_addr <= sr_q; // first byte sets the pointer
              end else begin
                o_wr_en <= 1'b1; // RULE8
                o_wr_data <= sr_q;
              end
            end
          end
          ST_WACK: begin
            if (scl_fall) begin
              state_q <= ST_WDATA;
              o_sda_oe <= 1'b0;
              cnt_q <= 4'h0;
              if (!first_q) o_addr <= o_addr + 8'h01;
              first_q <= 1'b0;
            end
          end
          ST_RDATA: begin
            if (scl_rise) begin
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall) begin
              if (cnt_q == BITS_PER_BYTE) begin
                state_q <= ST_RACK;
                o_sda_oe <= 1'b0;
                o_addr <= o_addr + 8'h01;
              end else begin
                tx_q <= {tx_q[6:0], 1'b0};
                o_sda_oe <= ~tx_q[6];
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              nack_q <= sda_f_q;
            end else if (scl_fall) begin
              cnt_q <= 4'h0;
              if (nack_q) begin
                state_q <= ST_IDLE;
              end else begin
                state_q <= ST_RDATA; // RULE8
                tx_q <= i_rd_data;
                o_sda_oe <= ~i_rd_data[7];
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
            o_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// [verif/board_host_model.sv]
// partner model: serial bus host plus board pins with LED and push switches
`timescale 1ns/1ns
module board_host_model
  import pin_port_pkg::*;
(
  input wire logic i_clk, // system clock
  input wire logic i_sda_oe, // device data drive enable
  input wire logic i_sda_out, // device data drive value
  input wire logic [7:0] i_pin_out, // device pin values
  input wire logic [7:0] i_pin_oe, // device pin enables
  output logic o_scl, // serial clock, idle high
  output logic o_sda, // resolved data line
  output logic [7:0] o_pin_in // resolved pin levels
);
  // ************************************************************
  // wires and board levels
  // ************************************************************
  logic scl_q = 1'b1;
  logic low_q = 1'b0;
  logic [7:0] ext_q = 8'h00; // switch levels on pins 6 and 0, others loose
  // open drain with pull-up, so a released line reads high
  assign o_sda = ~(low_q | (i_sda_oe & ~i_sda_out));
  assign o_scl = scl_q;
  // a driven pin shows the device value, the LED on pin 4 among them
  assign o_pin_in = (i_pin_oe & i_pin_out) | (~i_pin_oe & ext_q);
  // ************************************************************
  // bus cycles
  // ************************************************************
  // each clock phase well above the pin filter delay
  task automatic hc();
    repeat (12) @(negedge i_clk);
  endtask
  // also serves as repeated start
  task automatic start_c();
    low_q = 1'b0;
    hc();
    scl_q = 1'b1;
    hc();
    low_q = 1'b1;
    hc();
    scl_q = 1'b0;
    hc();
  endtask
  task automatic stop_c();
    low_q = 1'b1;
    hc();
    scl_q = 1'b1;
    hc();
    low_q = 1'b0;
    hc();
  endtask
  // data set while clock low, sampled late in the high phase
  task automatic pulse(input logic b, output logic s);
    low_q = ~b;
    hc();
    scl_q = 1'b1;
    hc();
    s = o_sda;
    scl_q = 1'b0;
    hc();
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(d[i], s);
    end
    pulse(1'b1, s);
    ack = ~s;
  endtask
  // last byte is answered with a release, which ends the read
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      pulse(1'b1, s);
      d[i] = s;
    end
    pulse(last, s);
  endtask
  task automatic write_regs(input logic [7:0] ofs, input logic [15:0] d, input int n,
                            output logic ok);
    logic a;
    start_c();
    put_byte({DEV_ADDR_DEFAULT, 1'b0}, ok);
    put_byte(ofs, a);
    ok = ok & a;
    for (int k = 0; k < n; k++) begin
      put_byte(d[8*k +: 8], a);
      ok = ok & a;
    end
    stop_c();
  endtask
  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d, output logic ok);
    logic a;
    start_c();
    put_byte({DEV_ADDR_DEFAULT, 1'b0}, ok);
    put_byte(ofs, a);
    ok = ok & a;
    start_c();
    put_byte({DEV_ADDR_DEFAULT, 1'b1}, a);
    ok = ok & a;
    get_byte(1'b1, d);
    stop_c();
  endtask
  task automatic probe(input logic [6:0] adr, output logic ack);
    start_c();
    put_byte({adr, 1'b0}, ack);
    stop_c();
  endtask
endmodule

// [verif/tb_transceiver_gpio_pin_port.sv]
// self-checking bench for the pin port: register rows, then edge cases
`timescale 1ns/1ns
module tb_transceiver_gpio_pin_port
  import pin_port_pkg::*;
;
  // ************************************************************
  // clock, reset and wiring
  // ************************************************************
  typedef struct packed {
    logic [7:0] wo;
    logic [7:0] wd;
    logic [7:0] ro;
    logic [7:0] re;
    logic [7:0] po;
    logic led;
  } row_t;
  // write offset, write data, read offset, read value, pin values, LED
  localparam row_t ROWS [14] = '{
    '{8'h4D, 8'h10, 8'h4D, 8'h10, 8'h00, 1'b0}, '{8'h4A, 8'h00, 8'h4A, 8'h00, 8'h00, 1'b0},
    '{8'h4B, 8'h10, 8'h4A, 8'h10, 8'h10, 1'b1}, '{8'h4B, 8'h03, 8'h4A, 8'h13, 8'h13, 1'b1},
    '{8'h4D, 8'h00, 8'h4D, 8'h00, 8'h13, 1'b0}, '{8'h4D, 8'h10, 8'h4D, 8'h10, 8'h13, 1'b1},
    '{8'h4C, 8'h10, 8'h4A, 8'h03, 8'h03, 1'b0}, '{8'h4C, 8'h01, 8'h4A, 8'h02, 8'h02, 1'b0},
    '{8'h4B, 8'h00, 8'h4C, 8'h00, 8'h02, 1'b0}, '{8'h4E, 8'h41, 8'h4E, 8'h41, 8'h02, 1'b0},
    '{8'h50, 8'h5A, 8'h50, 8'h5A, 8'h02, 1'b0}, '{8'h51, 8'hC3, 8'h51, 8'hC3, 8'h02, 1'b0},
    '{8'h52, 8'h7E, 8'h52, 8'h7E, 8'h02, 1'b0}, '{8'h60, 8'hFF, 8'h60, 8'h00, 8'h02, 1'b0}};
  // outside pin levels above, expected input register below
  localparam logic [15:0] EXT [4] = '{16'h4040, 16'hFF41, 16'hBE00, 16'h0101};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  int bad_count = 0;
  int total_checks = 0;
  logic scl;
  logic sda;
  logic sda_out;
  logic sda_oe;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic led;
  always #5 clk = ~clk;
  transceiver_gpio_pin_port dut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_SCL(scl), .I_SDA(sda), .O_SDA_OUT(sda_out),
    .O_SDA_OE(sda_oe), .I_PIN_IN(pin_in), .O_PIN_OUT(pin_out), .O_PIN_OE(pin_oe), .O_LED(led));
  board_host_model host (
    .i_clk(clk), .i_sda_oe(sda_oe), .i_sda_out(sda_out), .i_pin_out(pin_out),
    .i_pin_oe(pin_oe), .o_scl(scl), .o_sda(sda), .o_pin_in(pin_in));
  // ************************************************************
  // checking and closing
  // ************************************************************
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // watchdog: a hung run counts as a mismatch
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    logic [7:0] d;
    logic ok;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (12) @(negedge clk);
    check("oe_after_reset", pin_oe, 8'h00);
    check("led_after_reset", {7'h00, led}, 8'h00);
    check("sda_drive_after_reset", {7'h00, sda_out}, 8'h00);
    for (int i = 0; i < 14; i++) begin
      host.write_regs(ROWS[i].wo, {8'h00, ROWS[i].wd}, 1, ok);
      check("write_ack", {7'h00, ok}, 8'h01);
      host.read_reg(ROWS[i].ro, d, ok);
      check("read_ack", {7'h00, ok}, 8'h01);
      check("readback", d, ROWS[i].re);
      check("pin_out", pin_out, ROWS[i].po);
      check("led", {7'h00, led}, {7'h00, ROWS[i].led});
    end
    check("pin_oe_rows", pin_oe, 8'h10);
    // switches: only input-enabled pins show, pin 4 is driven low
    for (int i = 0; i < 4; i++) begin
      host.ext_q = EXT[i][15:8];
      host.read_reg(OFS_IN_LEVEL, d, ok);
      check("input_level", d, EXT[i][7:0]);
    end
    // a write to the read-only level register must not stick
    host.write_regs(OFS_IN_LEVEL, 16'h00FF, 1, ok);
    host.read_reg(OFS_IN_LEVEL, d, ok);
    check("read_only_level", d, 8'h01);
    // two data bytes in one frame land at consecutive offsets
    host.write_regs(OFS_INT_EN, 16'h2211, 2, ok);
    host.read_reg(OFS_INT_EN, d, ok);
    check("burst_first", d, 8'h11);
    host.read_reg(OFS_INT_INV, d, ok);
    check("burst_second", d, 8'h22);
    host.probe(DEV_ADDR_DEFAULT ^ 7'h01, ok);
    check("foreign_addr_ack", {7'h00, ok}, 8'h00);
    host.write_regs(OFS_DATA_SET, 16'h0010, 1, ok);
    check("led_lit", {7'h00, led}, 8'h01);
    // reset in mid-run clears drive and storage
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    check("led_in_reset", {7'h00, led}, 8'h00);
    rst_n = 1'b1;
    repeat (12) @(negedge clk);
    host.read_reg(OFS_DATA, d, ok);
    check("data_after_reset", d, 8'h00);
    wrap_up();
  end
endmodule
